// [hw/swrc_top.sv]
// sleep control, wake-up detection and reset-cause flags
`timescale 1ns/1ns
`include "swrc_consts.svh"
module swrc_top #(
  parameter int IO_W = 4,
  parameter logic [31:0] POR_CYCLES = 32'(`SWRC_POR_CYC),
  parameter logic [31:0] WDT_CYCLES = 32'(`SWRC_WDT_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_external_reset_pin_b,
  input wire logic [`SWRC_WATCHED_W-1:0] i_watched,
  input wire logic i_comparator_out,
  input wire logic i_sleep_exec,
  input wire logic i_clear_watchdog,
  input wire logic i_port_access,
  input wire logic [IO_W-1:0] i_io_out,
  input wire logic [IO_W-1:0] i_io_oe,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [IO_W-1:0] o_io_out,
  output logic [IO_W-1:0] o_io_oe,
  output logic o_core_reset,
  output logic o_osc_enable,
  output logic o_sleeping,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic o_pin_wake_flag,
  output logic o_comparator_wake_flag,
  output logic o_external_reset_pin_out,
  output logic o_external_reset_pin_oe
);
  localparam logic [31:0] HOLD_CYCLES = 32'(`SWRC_HOLD_CYC);

  swrc_pkg::swrc_state_t state;
  swrc_pkg::swrc_state_t next_state;
  logic [31:0] hold;
  logic [31:0] next_hold;
  logic timeout_flag;
  logic powerdown_flag;
  logic pin_wake_flag;
  logic comparator_wake_flag;
  logic next_timeout_flag;
  logic next_powerdown_flag;
  logic next_pin_wake_flag;
  logic next_comparator_wake_flag;
  logic [3:0] ctrl;
  logic [2:0] wdt_prescale;
  logic [`SWRC_WATCHED_W-1:0] captured;
  logic cmp_ref;
  logic wdt_expire;
  logic wdt_clear;
  logic ext_assert;
  logic pin_change;
  logic cmp_change;
  logic running;
  logic sleep_enter;

  assign running = (state == swrc_pkg::ST_RUN);
  assign sleep_enter = running && i_sleep_exec && !ext_assert && !wdt_expire;
  assign ext_assert = ctrl[`SWRC_CTRL_RST_FN_EN] && !i_external_reset_pin_b;
  assign pin_change = ctrl[`SWRC_CTRL_PIN_WAKE_EN] && (i_watched != captured);
  assign cmp_change = ctrl[`SWRC_CTRL_CMP_WAKE_EN] && (i_comparator_out != cmp_ref);

  // watchdog is held clear whenever the core is in reset, so it cannot fire mid-hold
  assign wdt_clear = (running && i_clear_watchdog) || sleep_enter
    || (next_state != swrc_pkg::ST_RUN && next_state != swrc_pkg::ST_SLEEP);

  swrc_wdog #(
    .BASE_CYCLES(WDT_CYCLES)
  ) u_wdog (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_enable(ctrl[`SWRC_CTRL_WDT_EN]),
    .i_clear(wdt_clear),
    .i_prescale(wdt_prescale),
    .o_expire(wdt_expire)
  );

  always_comb
  begin
    next_state = state;
    next_hold = hold;
    next_timeout_flag = timeout_flag;
    next_powerdown_flag = powerdown_flag;
    next_pin_wake_flag = pin_wake_flag;
    next_comparator_wake_flag = comparator_wake_flag;
    unique case (state)
      swrc_pkg::ST_POR_WAIT:
      begin
        if (!ext_assert)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = POR_CYCLES;
        end
      end
      swrc_pkg::ST_EXT_HELD:
      begin
        if (!ext_assert)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = HOLD_CYCLES;
        end
      end
      swrc_pkg::ST_HOLD:
      begin
        if (ext_assert)
        begin
          next_state = swrc_pkg::ST_EXT_HELD;
        end
        else if (hold <= 32'h1)
        begin
          next_state = swrc_pkg::ST_RUN;
          next_hold = 32'h0;
        end
        else
        begin
          next_hold = hold - 32'h1;
        end
      end
      swrc_pkg::ST_RUN:
      begin
        if (ext_assert)
        begin
          next_state = swrc_pkg::ST_EXT_HELD;
          next_pin_wake_flag = 1'b0;
          next_comparator_wake_flag = 1'b0;
        end
        else if (wdt_expire)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = HOLD_CYCLES;
          next_timeout_flag = 1'b0;
          next_pin_wake_flag = 1'b0;
          next_comparator_wake_flag = 1'b0;
        end
        else if (i_sleep_exec)
        begin
          next_state = swrc_pkg::ST_SLEEP;
          next_timeout_flag = 1'b1;
          next_powerdown_flag = 1'b0;
        end
      end
      swrc_pkg::ST_SLEEP:
      begin
        // priority when wake events coincide: pin reset, watchdog, pins, comparator
        if (ext_assert)
        begin
          next_state = swrc_pkg::ST_EXT_HELD;
          next_timeout_flag = 1'b1;
          next_powerdown_flag = 1'b0;
          next_pin_wake_flag = 1'b0;
          next_comparator_wake_flag = 1'b0;
        end
        else if (wdt_expire)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = HOLD_CYCLES;
          next_timeout_flag = 1'b0;
          next_powerdown_flag = 1'b0;
          next_pin_wake_flag = 1'b0;
          next_comparator_wake_flag = 1'b0;
        end
        else if (pin_change)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = HOLD_CYCLES;
          next_timeout_flag = 1'b1;
          next_powerdown_flag = 1'b0;
          next_pin_wake_flag = 1'b1;
          next_comparator_wake_flag = 1'b0;
        end
        else if (cmp_change)
        begin
          next_state = swrc_pkg::ST_HOLD;
          next_hold = HOLD_CYCLES;
          next_timeout_flag = 1'b1;
          next_powerdown_flag = 1'b0;
          next_pin_wake_flag = 1'b0;
          next_comparator_wake_flag = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= swrc_pkg::ST_POR_WAIT;
      hold <= 32'h0;
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
      pin_wake_flag <= 1'b0;
      comparator_wake_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      hold <= next_hold;
      // flags move only with the reset and sleep events above
      timeout_flag <= next_timeout_flag;
      powerdown_flag <= next_powerdown_flag;
      pin_wake_flag <= next_pin_wake_flag;
      comparator_wake_flag <= next_comparator_wake_flag;
    end
  end

  // pin reference tracks port accesses only; sleep entry does not refresh it
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      captured <= '0;
      cmp_ref <= 1'b0;
    end
    else if (i_ce)
    begin
      if (running && i_port_access)
      begin
        captured <= i_watched;
      end
      if (sleep_enter)
      begin
        cmp_ref <= i_comparator_out;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_io_out <= '0;
      o_io_oe <= '0;
    end
    else if (i_ce && next_state != swrc_pkg::ST_SLEEP)
    begin
      o_io_out <= i_io_out;
      o_io_oe <= i_io_oe;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_core_reset <= 1'b1;
      o_osc_enable <= 1'b1;
      o_sleeping <= 1'b0;
      o_timeout_flag <= 1'b1;
      o_powerdown_flag <= 1'b1;
      o_pin_wake_flag <= 1'b0;
      o_comparator_wake_flag <= 1'b0;
      o_external_reset_pin_out <= 1'b0;
      o_external_reset_pin_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_core_reset <= (next_state != swrc_pkg::ST_RUN) && (next_state != swrc_pkg::ST_SLEEP);
      o_osc_enable <= (next_state != swrc_pkg::ST_SLEEP);
      o_sleeping <= (next_state == swrc_pkg::ST_SLEEP);
      o_timeout_flag <= next_timeout_flag;
      o_powerdown_flag <= next_powerdown_flag;
      o_pin_wake_flag <= next_pin_wake_flag;
      o_comparator_wake_flag <= next_comparator_wake_flag;
      // the block never pulls the reset pin, whatever the reset source
      o_external_reset_pin_out <= 1'b0;
      o_external_reset_pin_oe <= 1'b0;
    end
  end

  // configuration survives every reset but power-up
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl <= `SWRC_CTRL_RESET;
      wdt_prescale <= `SWRC_WDT_PS_RESET;
    end
    else if (i_ce && i_wr)
    begin
      if (i_addr == `SWRC_ADDR_CTRL)
      begin
        ctrl <= i_wdata[3:0];
      end
      if (i_addr == `SWRC_ADDR_WDT)
      begin
        wdt_prescale <= i_wdata[2:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      o_rdata <= 8'h00;
      if (i_rd)
      begin
        unique case (i_addr)
          `SWRC_ADDR_CTRL: o_rdata <= {4'h0, ctrl};
          `SWRC_ADDR_STATUS:
          begin
            o_rdata[`SWRC_ST_PD] <= powerdown_flag;
            o_rdata[`SWRC_ST_TO] <= timeout_flag;
            o_rdata[`SWRC_ST_PIN] <= pin_wake_flag;
            o_rdata[`SWRC_ST_CMP] <= comparator_wake_flag;
            o_rdata[`SWRC_ST_SLEEP] <= (state == swrc_pkg::ST_SLEEP);
          end
          `SWRC_ADDR_WDT: o_rdata <= {5'h00, wdt_prescale};
          `SWRC_ADDR_CAPT: o_rdata <= {5'h00, captured};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : swrc_top

// [hw/swrc_consts.svh]
// constants for the sleep, wake and reset-cause block
`ifndef SWRC_CONSTS_SVH
`define SWRC_CONSTS_SVH

`define SWRC_CLK_HZ 64'd20000000
`define SWRC_T_HOLD_NS 64'd10000
`define SWRC_T_POR_US 64'd18000
`define SWRC_T_WDT_US 64'd18000
`define SWRC_HOLD_CYC ((`SWRC_T_HOLD_NS * `SWRC_CLK_HZ + 64'd999999999) / 64'd1000000000)
`define SWRC_POR_CYC ((`SWRC_T_POR_US * `SWRC_CLK_HZ + 64'd999999) / 64'd1000000)
`define SWRC_WDT_CYC ((`SWRC_T_WDT_US * `SWRC_CLK_HZ) / 64'd1000000)

`define SWRC_ADDR_CTRL 4'h0
`define SWRC_ADDR_STATUS 4'h1
`define SWRC_ADDR_WDT 4'h2
`define SWRC_ADDR_CAPT 4'h3

`define SWRC_CTRL_WDT_EN 0
`define SWRC_CTRL_PIN_WAKE_EN 1
`define SWRC_CTRL_CMP_WAKE_EN 2
`define SWRC_CTRL_RST_FN_EN 3
`define SWRC_CTRL_RESET 4'h9

`define SWRC_ST_PD 0
`define SWRC_ST_TO 1
`define SWRC_ST_PIN 2
`define SWRC_ST_CMP 3
`define SWRC_ST_SLEEP 4

`define SWRC_WDT_PS_RESET 3'h0
`define SWRC_WATCHED_W 3

`endif

// [hw/swrc_pkg.sv]
// types for the sleep, wake and reset-cause block
package swrc_pkg;
  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_EXT_HELD,
    ST_HOLD,
    ST_RUN,
    ST_SLEEP
  } swrc_state_t;
endpackage : swrc_pkg

// [hw/swrc_wdog.sv]
// watchdog counter with power-of-two prescale
`timescale 1ns/1ns
`include "swrc_consts.svh"
module swrc_wdog #(
  parameter logic [31:0] BASE_CYCLES = 32'(`SWRC_WDT_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic i_clear,
  input wire logic [2:0] i_prescale,
  output logic o_expire
);
  logic [31:0] count;
  logic [31:0] limit;

  assign limit = (BASE_CYCLES << i_prescale) - 32'h1;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      count <= 32'h0;
      o_expire <= 1'b0;
    end
    else if (i_ce)
    begin
      o_expire <= 1'b0;
      if (i_clear || !i_enable)
      begin
        count <= 32'h0;
      end
      else if (count >= limit)
      begin
        // restart so an ignored expiry repeats one period later
        count <= 32'h0;
        o_expire <= 1'b1;
      end
      else
      begin
        count <= count + 32'h1;
      end
    end
  end
endmodule : swrc_wdog

// [bench/swrc_top_chk.sv]
// assertions on the ports of the sleep, wake and reset-cause block
`timescale 1ns/1ns
module swrc_top_chk #(
  parameter int IO_W = 4
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_external_reset_pin_b,
  input wire logic [IO_W-1:0] o_io_out,
  input wire logic [IO_W-1:0] o_io_oe,
  input wire logic o_core_reset,
  input wire logic o_osc_enable,
  input wire logic o_sleeping,
  input wire logic o_timeout_flag,
  input wire logic o_powerdown_flag,
  input wire logic o_pin_wake_flag,
  input wire logic o_comparator_wake_flag,
  input wire logic o_external_reset_pin_out,
  input wire logic o_external_reset_pin_oe
);
  logic [15:0] hold_cnt;
  logic ran;
  logic [3:0] flags;
  assign flags = {o_timeout_flag, o_powerdown_flag, o_pin_wake_flag, o_comparator_wake_flag};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // counts hold cycles after the pin is released; power-up hold is excluded via ran
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hold_cnt <= '0;
      ran <= 1'h0;
    end
    else
    begin
      hold_cnt <= (o_core_reset && i_external_reset_pin_b) ? hold_cnt + 16'h1 : '0;
      ran <= ran | !o_core_reset;
    end
  end
  AST_POR_FLAGS: assert property ($rose(i_rst_b) |-> flags == 4'hc)
    else $error("power-up flags wrong");
  AST_SLEEP_ENTRY: assert property ($rose(o_sleeping) |-> o_timeout_flag && !o_powerdown_flag)
    else $error("sleep entry flags wrong");
  AST_OSC_STOPPED: assert property (o_sleeping |-> !o_osc_enable && !o_core_reset)
    else $error("oscillator runs in sleep");
  AST_IO_FROZEN: assert property (o_sleeping && $past(o_sleeping) |-> $stable(o_io_out) && $stable(o_io_oe))
    else $error("pins moved in sleep");
  AST_PIN_NOT_DRIVEN: assert property (!o_external_reset_pin_oe && !o_external_reset_pin_out)
    else $error("reset pin driven");
  AST_WAKE_IS_RESET: assert property ($fell(o_sleeping) |-> o_core_reset && o_osc_enable)
    else $error("wake without reset");
  AST_FLAGS_HELD: assert property (!$past(o_core_reset) && !o_core_reset && !$rose(o_sleeping) |-> $stable(flags))
    else $error("flags changed while running");
  AST_FLAGS_IN_HOLD: assert property (o_core_reset && $past(o_core_reset) |-> $stable(flags))
    else $error("flags changed in hold");
  AST_HOLD_LEN: assert property ($fell(o_core_reset) && ran |-> hold_cnt >= 16'hc8 && hold_cnt <= 16'hca)
    else $error("hold length wrong");
  AST_PIN_WAKE: assert property ($rose(o_pin_wake_flag) |-> flags == 4'ha && $rose(o_core_reset))
    else $error("pin wake flags wrong");
  AST_CMP_WAKE: assert property ($rose(o_comparator_wake_flag) |-> flags == 4'h9 && $rose(o_core_reset))
    else $error("comparator wake flags wrong");
  AST_WDT_WAKE: assert property ($fell(o_sleeping) && !o_timeout_flag |-> flags == 4'h0)
    else $error("watchdog wake flags wrong");
endmodule : swrc_top_chk

bind swrc_top swrc_top_chk #(.IO_W(IO_W)) u_chk (.i_clock, .i_rst_b, .i_external_reset_pin_b,
  .o_io_out, .o_io_oe, .o_core_reset, .o_osc_enable, .o_sleeping, .o_timeout_flag,
  .o_powerdown_flag, .o_pin_wake_flag, .o_comparator_wake_flag, .o_external_reset_pin_out,
  .o_external_reset_pin_oe);

// [bench/swrc_far_side.sv]
// outside world: reset pin, watched inputs and comparator output
`timescale 1ns/1ns
module swrc_far_side (
  input wire logic i_clock,
  input wire logic i_press,
  input wire logic [2:0] i_level,
  input wire logic i_cmp_level,
  output logic o_reset_pin_b,
  output logic [2:0] o_watched,
  output logic o_comparator_out
);
  // pin has a pull-up, so it idles high unless pressed
  initial
  begin
    o_reset_pin_b = 1'h1;
    o_watched = 3'h0;
    o_comparator_out = 1'h0;
  end
  always @(posedge i_clock)
  begin
    o_reset_pin_b <= !i_press;
    o_watched <= i_level;
    o_comparator_out <= i_cmp_level;
  end
endmodule : swrc_far_side

// [bench/swrc_top_bench.sv]
// self-checking bench for the sleep, wake and reset-cause block
`timescale 1ns/1ns
`include "swrc_consts.svh"
module swrc_top_bench;
  logic i_clock, i_rst_b, i_sleep_exec, i_port_access, i_wr, i_rd, press, cmp_lvl;
  logic [3:0] i_addr, i_io_out;
  logic [7:0] i_wdata, o_rdata;
  logic [2:0] lvl, watched;
  logic ext_pin_b, cmp_out, o_core_reset, o_osc_enable, o_sleeping;
  logic [3:0] o_io_out;
  logic ce, clr_wdt;
  logic [3:0] io_oe, o_io_oe;
  int fail_count, total_checks;
  swrc_top #(.POR_CYCLES(32'h32), .WDT_CYCLES(32'h28)) DUT (.i_clock, .i_rst_b, .i_ce(ce),
    .i_external_reset_pin_b(ext_pin_b), .i_watched(watched), .i_comparator_out(cmp_out),
    .i_sleep_exec, .i_clear_watchdog(clr_wdt), .i_port_access, .i_io_out, .i_io_oe(io_oe),
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_io_out, .o_io_oe(o_io_oe), .o_core_reset,
    .o_osc_enable, .o_sleeping, .o_timeout_flag(), .o_powerdown_flag(), .o_pin_wake_flag(),
    .o_comparator_wake_flag(), .o_external_reset_pin_out(), .o_external_reset_pin_oe());
  swrc_far_side u_far (.i_clock, .i_press(press), .i_level(lvl), .i_cmp_level(cmp_lvl),
    .o_reset_pin_b(ext_pin_b), .o_watched(watched), .o_comparator_out(cmp_out));
  initial
  begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 chk(o_rdata, exp);
  endtask : rd
  task automatic go_sleep(input logic cap);
    @(posedge i_clock);
    i_port_access <= cap;
    @(posedge i_clock);
    i_port_access <= 1'h0;
    i_sleep_exec <= 1'h1;
    @(posedge i_clock);
    i_sleep_exec <= 1'h0;
  endtask : go_sleep
  task automatic press_pin;
    press <= 1'h1;
    repeat (5) @(posedge i_clock);
    press <= 1'h0;
    repeat (2) @(posedge i_clock);
  endtask : press_pin
  // bounded so a stuck reset ends the run instead of hanging it
  task automatic wait_reset(input logic want);
    int n;
    n = 0;
    while (o_core_reset !== want && n < 3000)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n == 3000)
    begin
      fail_count++;
      $display("[FAIL] %0t core reset wait timed out", $time);
      report_and_stop();
    end
  endtask : wait_reset
  task automatic expect_wake(input logic [7:0] exp);
    wait_reset(1'h1);
    rd(`SWRC_ADDR_STATUS, exp);
    wait_reset(1'h0);
  endtask : expect_wake
  initial
  begin
    {i_rst_b, i_sleep_exec, i_port_access, i_wr, i_rd, press, cmp_lvl} = 7'h0;
    {i_addr, i_io_out, i_wdata, lvl} = 19'h0;
    ce = 1'h1;
    clr_wdt = 1'h0;
    io_oe = 4'hf;
    fail_count = 0;
    total_checks = 0;
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'h1;
    wait_reset(1'h0);
    rd(`SWRC_ADDR_STATUS, 8'h03);
    rd(`SWRC_ADDR_CTRL, 8'h09);
    rd(`SWRC_ADDR_WDT, 8'h00);
    rd(4'hf, 8'h00);
    wr(`SWRC_ADDR_STATUS, 8'hff);
    rd(`SWRC_ADDR_STATUS, 8'h03);
    expect_wake(8'h01);
    wr(`SWRC_ADDR_CTRL, 8'h06);
    i_io_out <= 4'h5;
    io_oe <= 4'h3;
    go_sleep(1'h1);
    rd(`SWRC_ADDR_STATUS, 8'h12);
    chk({7'h0, o_osc_enable}, 8'h00);
    @(posedge i_clock);
    i_io_out <= 4'ha;
    io_oe <= 4'hc;
    press_pin();
    #1 chk({7'h0, o_sleeping}, 8'h01);
    chk({4'h0, o_io_out}, 8'h05);
    chk({4'h0, o_io_oe}, 8'h03);
    lvl <= 3'h4;
    expect_wake(8'h06);
    chk({4'h0, o_io_oe}, 8'h0c);
    wr(`SWRC_ADDR_CTRL, 8'h0e);
    press_pin();
    expect_wake(8'h02);
    go_sleep(1'h0);
    expect_wake(8'h06);
    go_sleep(1'h1);
    repeat (20) @(posedge i_clock);
    #1 chk({7'h0, o_sleeping}, 8'h01);
    // clock enable low must hide the comparator change until it returns
    @(posedge i_clock);
    ce <= 1'h0;
    cmp_lvl <= 1'h1;
    repeat (10) @(posedge i_clock);
    #1 chk({7'h0, o_sleeping}, 8'h01);
    @(posedge i_clock);
    ce <= 1'h1;
    expect_wake(8'h0a);
    wr(`SWRC_ADDR_CTRL, 8'h08);
    go_sleep(1'h1);
    lvl <= 3'h1;
    cmp_lvl <= 1'h0;
    repeat (100) @(posedge i_clock);
    #1 chk({7'h0, o_sleeping}, 8'h01);
    press_pin();
    expect_wake(8'h02);
    wr(`SWRC_ADDR_CTRL, 8'h01);
    go_sleep(1'h1);
    expect_wake(8'h00);
    repeat (30) @(posedge i_clock);
    #1 chk({7'h0, o_core_reset}, 8'h00);
    // clears spaced inside the period keep the watchdog from firing
    repeat (4)
    begin
      @(posedge i_clock);
      clr_wdt <= 1'h1;
      @(posedge i_clock);
      clr_wdt <= 1'h0;
      repeat (25) @(posedge i_clock);
    end
    #1 chk({7'h0, o_core_reset}, 8'h00);
    expect_wake(8'h00);
    @(posedge i_clock);
    i_rst_b <= 1'h0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'h1;
    wait_reset(1'h0);
    rd(`SWRC_ADDR_STATUS, 8'h03);
    report_and_stop();
  end
endmodule : swrc_top_bench
